// *** core/lvmon_pkg.sv ***
package lvmon_pkg;
   // register map (byte addresses)
   localparam logic [11:0] LVMON_CTRL_ADDR   = 12'h000;
   localparam logic [11:0] LVMON_IRQ_ADDR    = 12'h004;
   localparam logic [11:0] LVMON_SLEEP_ADDR  = 12'h008;
   localparam logic [11:0] LVMON_STAT_ADDR   = 12'h00c;
   // control register fields
   localparam int          LVMON_LOW_BIT     = 5;
   localparam int          LVMON_EN_BIT      = 4;
   localparam int          LVMON_SEL_LSB     = 0;
   localparam int          LVMON_SEL_W       = 3;
   localparam logic [7:0]  LVMON_CTRL_RESET  = 8'h00;
   // irq register fields
   localparam int          LVMON_REQ_BIT     = 0;
   localparam int          LVMON_IEN_BIT     = 1;
   // status and sleep register fields
   localparam int          LVMON_SETTLED_BIT = 0;
   localparam int          LVMON_SLEEP_BIT   = 0;
   // timing
   localparam int          LVMON_CLK_MHZ     = 40;
   localparam int          LVMON_SETTLE_US   = 15;
   localparam int          LVMON_QUAL_US     = 15;
   localparam int          LVMON_SETTLE_CYC  = LVMON_SETTLE_US * LVMON_CLK_MHZ;
   localparam int          LVMON_QUAL_CYC    = LVMON_QUAL_US * LVMON_CLK_MHZ;
   localparam int          LVMON_CNT_W       = 16;
   // trip level codes in tens of millivolts
   localparam logic [8:0]  LVMON_LVL_2V0     = 9'h0c8;
   localparam logic [8:0]  LVMON_LVL_2V2     = 9'h0dc;
   localparam logic [8:0]  LVMON_LVL_2V4     = 9'h0f0;
   localparam logic [8:0]  LVMON_LVL_2V7     = 9'h10e;
   localparam logic [8:0]  LVMON_LVL_3V0     = 9'h12c;
   localparam logic [8:0]  LVMON_LVL_3V3     = 9'h14a;
   localparam logic [8:0]  LVMON_LVL_3V6     = 9'h168;
   localparam logic [8:0]  LVMON_LVL_4V0     = 9'h190;
endpackage

// *** core/lvmon_sync.sv ***
`timescale 1ns/100ps
module lvmon_sync
   import lvmon_pkg::*;
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // data
   input  wire logic din,
   output logic      dout
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } lvmon_sync_t;
   lvmon_sync_t st_q, st_d;

   always_comb begin
      st_d    = st_q;
      st_d.s1 = din;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      if (st_q.s2 == st_q.s3) begin
         st_d.q = st_q.s3;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign dout = st_q.q;
endmodule

// *** core/lvmon_timer.sv ***
`timescale 1ns/100ps
module lvmon_timer
   import lvmon_pkg::*;
#(
   parameter int CYCLES = LVMON_QUAL_CYC
)(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control
   input  wire logic run,
   output logic      done
);
   typedef struct packed {
      logic [LVMON_CNT_W-1:0] cnt;
      logic                   done;
   } lvmon_timer_t;
   lvmon_timer_t st_q, st_d;
   localparam logic [LVMON_CNT_W-1:0] LAST = LVMON_CNT_W'(CYCLES - 1);

   // counts while run is high; done rises after CYCLES cycles and holds
   always_comb begin
      st_d = st_q;
      if (!run) begin
         st_d = '0;
      end else if (!st_q.done) begin
         if (st_q.cnt == LAST) begin
            st_d.done = 1'b1;
         end else begin
            st_d.cnt = st_q.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign done = st_q.done;
endmodule

// *** core/lvmon_ctrl.sv ***
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module lvmon_ctrl
   import lvmon_pkg::*;
#(
   parameter int QUAL_CYCLES   = LVMON_QUAL_CYC,
   parameter int SETTLE_CYCLES = LVMON_SETTLE_CYC
)(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // analog front end
   input  wire logic [8:0]  supply_mv10,
   output logic             ref_on,
   output logic             detector_active,
   // system
   output logic             mfi_irq,
   output logic             wake_req
);
   typedef struct packed {
      logic [LVMON_SEL_W-1:0] trip_level_sel;
      logic                   detector_on;
      logic                   req;
      logic                   irq_en;
      logic                   sleeping;
      logic                   low_prev;
      logic                   ready;
      logic [31:0]            rdata;
      logic                   slverr;
      logic                   irq;
      logic                   wake;
   } lvmon_state_t;
   lvmon_state_t st_q, st_d;

   logic [8:0] trip_mv10;
   logic       cmp_raw;
   logic       supply_low_flag;
   logic       qual_done;
   logic       settled;
   logic       access;
   logic       wr_ok;
   logic [7:0] ctrl_rd;

   // trip level table
   always_comb begin
      unique case (st_q.trip_level_sel)
         3'h0: trip_mv10 = LVMON_LVL_2V0;
         3'h1: trip_mv10 = LVMON_LVL_2V2;
         3'h2: trip_mv10 = LVMON_LVL_2V4;
         3'h3: trip_mv10 = LVMON_LVL_2V7;
         3'h4: trip_mv10 = LVMON_LVL_3V0;
         3'h5: trip_mv10 = LVMON_LVL_3V3;
         3'h6: trip_mv10 = LVMON_LVL_3V6;
         3'h7: trip_mv10 = LVMON_LVL_4V0;
      endcase
   end

   // comparator gated by enable, also in sleep
   assign cmp_raw = st_q.detector_on & (supply_mv10 < trip_mv10);

   // synchronised, and a new level passes only once two successive samples agree
   lvmon_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (cmp_raw),
      .dout    (supply_low_flag)
   );

   lvmon_timer #(.CYCLES(QUAL_CYCLES)) u_qual (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (supply_low_flag),
      .done    (qual_done)
   );

   lvmon_timer #(.CYCLES(SETTLE_CYCLES)) u_settle (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (st_q.detector_on),
      .done    (settled)
   );

   assign access = psel & penable;
   assign wr_ok  = access & pwrite & pstrb[0];
   assign ctrl_rd = {2'b00, supply_low_flag, st_q.detector_on, 1'b0,
                     st_q.trip_level_sel};

   always_comb begin
      st_d          = st_q;
      st_d.ready    = 1'b0;
      st_d.slverr   = 1'b0;
      st_d.rdata    = '0;
      st_d.low_prev = qual_done;
      st_d.wake     = 1'b0;
      if (psel && !penable) begin
         st_d.ready = 1'b1;
         if (!pwrite) begin
            unique case (paddr)
               LVMON_CTRL_ADDR:  st_d.rdata = {24'h000000, ctrl_rd};
               LVMON_IRQ_ADDR:   st_d.rdata = {30'h00000000, st_q.irq_en, st_q.req};
               LVMON_SLEEP_ADDR: st_d.rdata = {31'h00000000, st_q.sleeping};
               LVMON_STAT_ADDR:  st_d.rdata = {31'h00000000, settled};
               default:          st_d.slverr = 1'b1;
            endcase
         end else begin
            unique case (paddr)
               LVMON_CTRL_ADDR, LVMON_IRQ_ADDR, LVMON_SLEEP_ADDR: st_d.slverr = 1'b0;
               default: st_d.slverr = 1'b1;
            endcase
         end
      end
      if (wr_ok) begin
         unique case (paddr)
            LVMON_CTRL_ADDR: begin
               st_d.trip_level_sel = pwdata[LVMON_SEL_LSB +: LVMON_SEL_W];
               st_d.detector_on    = pwdata[LVMON_EN_BIT];
            end
            LVMON_IRQ_ADDR: begin
               st_d.req    = pwdata[LVMON_REQ_BIT];
               st_d.irq_en = pwdata[LVMON_IEN_BIT];
            end
            LVMON_SLEEP_ADDR: st_d.sleeping = pwdata[LVMON_SLEEP_BIT];
            default: st_d.sleeping = st_q.sleeping;
         endcase
      end
      // qualified rise sets the request and wins over a clear while enabled; while disabled it clears it and a write wins
      if (qual_done && !st_q.low_prev) begin
         st_d.req = 1'b1;
         if (!st_q.req) begin
            st_d.wake = st_q.sleeping;
         end
      end
      if (!st_q.detector_on) begin
         st_d.req = st_q.req & ~(qual_done && !st_q.low_prev);
         st_d.wake = 1'b0;
         if (wr_ok && paddr == LVMON_IRQ_ADDR) begin
            st_d.req = pwdata[LVMON_REQ_BIT];
         end
      end
      st_d.irq = st_d.req & st_d.irq_en;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pready          = st_q.ready;
   assign prdata          = st_q.rdata;
   assign pslverr         = st_q.slverr;
   assign ref_on          = st_q.detector_on;
   assign detector_active = st_q.detector_on;
   assign mfi_irq         = st_q.irq;
   assign wake_req        = st_q.wake;

   a_reset_clear: assert property (@(posedge pclk)
      $rose(presetn) |-> (st_q.detector_on == 1'b0 && st_q.trip_level_sel == 3'h0))
      else $error("control not cleared after reset");
   a_off_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
      !st_q.detector_on [*5] |-> !supply_low_flag)
      else $error("flag high while off");
   a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_rd[7:6] == 2'b00 && ctrl_rd[3] == 1'b0)
      else $error("unused bits not zero");
   a_ref_follows: assert property (@(posedge pclk) disable iff (!presetn)
      ref_on == st_q.detector_on)
      else $error("reference not following enable");
   a_en_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ok && paddr == LVMON_CTRL_ADDR |=> st_q.detector_on == $past(pwdata[LVMON_EN_BIT]))
      else $error("enable write lost");
   a_qual_wait: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(qual_done) |-> $past(supply_low_flag, 2))
      else $error("request qualified too early");
   a_req_set: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(qual_done) && st_q.detector_on |=> st_q.req)
      else $error("request not set");
   a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      mfi_irq == (st_q.req && st_q.irq_en))
      else $error("irq not following request");
   a_wake_edge: assert property (@(posedge pclk) disable iff (!presetn)
      wake_req |-> $past(!st_q.req) && st_q.req)
      else $error("wake without rising request");
endmodule

// *** dv/lvmon_ctrl_tb_top.sv ***
`timescale 1ns/100ps
module lvmon_ctrl_tb_top
   import lvmon_pkg::*;
;
   localparam int         QUAL = 8;
   localparam logic [8:0] LVL_TAB [8] = '{LVMON_LVL_2V0, LVMON_LVL_2V2, LVMON_LVL_2V4,
      LVMON_LVL_2V7, LVMON_LVL_3V0, LVMON_LVL_3V3, LVMON_LVL_3V6, LVMON_LVL_4V0};
   logic        pclk        = 1'b0;
   logic        presetn     = 1'b0;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [11:0] paddr       = 12'h000;
   logic [31:0] pwdata      = 32'h0;
   logic [3:0]  pstrb       = 4'h0;
   logic [8:0]  supply_mv10 = 9'h1f4;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        ref_on;
   logic        detector_active;
   logic        mfi_irq;
   logic        wake_req;
   int          n_errors    = 0;
   int          check_count = 0;
   int          cyc         = 0;
   int          wake_n      = 0;
   logic [31:0] rng         = 32'h8f33243c;

   lvmon_ctrl #(.QUAL_CYCLES(QUAL), .SETTLE_CYCLES(QUAL)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .supply_mv10(supply_mv10), .ref_on(ref_on),
      .detector_active(detector_active), .mfi_irq(mfi_irq), .wake_req(wake_req));

   always #12.5 pclk = ~pclk;

   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   // expected control word: flag, enable, zero, level select
   function automatic logic [31:0] exp_ctrl(logic en, logic [2:0] s, logic [8:0] v);
      return {26'h0, en && (v < LVL_TAB[s]), en, 1'b0, s};
   endfunction

   task automatic chk_word(string name, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_bit(string name, logic exp, logic got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(logic [11:0] a, logic [31:0] d);
      logic [31:0] x;
      logic        e;
      apb(1'b1, a, d, x, e);
   endtask

   task automatic rd(logic [11:0] a, output logic [31:0] x);
      logic e;
      apb(1'b0, a, 32'h0, x, e);
   endtask

   task automatic wait_cyc(int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic complete_run();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // wake pulses seen, and a ceiling on run length
   always @(posedge pclk) begin
      cyc++;
      if (wake_req === 1'b1)
         wake_n++;
      if (cyc == 20000) begin
         n_errors++;
         complete_run();
      end
   end

   initial begin
      logic [31:0] x;
      logic [31:0] d;
      logic [8:0]  v;
      logic        e;
      int          w0;
      wait_cyc(20);
      presetn <= 1'b1;
      rd(LVMON_CTRL_ADDR, x);
      chk_word("ctrl reset", 32'(LVMON_CTRL_RESET), x);
      rd(LVMON_IRQ_ADDR, x);
      chk_word("irq reset", 32'h0, x);
      chk_bit("ref reset", 1'b0, ref_on);
      for (int i = 0; i < 8; i++) begin
         d = rnd();
         wr(LVMON_CTRL_ADDR, d);
         rd(LVMON_CTRL_ADDR, x);
         chk_word("ctrl rw", exp_ctrl(d[4], d[2:0], supply_mv10), x);
         chk_bit("ref follows", d[4], ref_on);
         chk_bit("active follows", d[4], detector_active);
      end
      // each trip level, supply just below then just above
      for (int s = 0; s < 8; s++) begin
         wr(LVMON_CTRL_ADDR, 32'h10 | s);
         for (int k = 0; k < 2; k++) begin
            v = k ? LVL_TAB[s] + 9'(1 + rnd() % 8) : LVL_TAB[s] - 9'(1 + rnd() % 8);
            supply_mv10 <= v;
            wait_cyc(12);
            rd(LVMON_CTRL_ADDR, x);
            chk_word("level flag", exp_ctrl(1'b1, 3'(s), v), x);
         end
      end
      wr(LVMON_CTRL_ADDR, 32'h0);
      supply_mv10 <= 9'h064;
      wr(LVMON_IRQ_ADDR, 32'h0);
      wait_cyc(4 * QUAL);
      rd(LVMON_CTRL_ADDR, x);
      chk_word("off flag", 32'h0, x);
      rd(LVMON_IRQ_ADDR, x);
      chk_word("off request", 32'h0, x);
      supply_mv10 <= 9'h1f4;
      wr(LVMON_CTRL_ADDR, 32'h17);
      rd(LVMON_STAT_ADDR, x);
      chk_word("not settled", 32'h0, x);
      wait_cyc(2 * QUAL);
      rd(LVMON_STAT_ADDR, x);
      chk_word("settled", 32'h1, x);
      wr(LVMON_IRQ_ADDR, 32'h0);
      wr(LVMON_IRQ_ADDR, 32'h2);
      supply_mv10 <= 9'h064;
      wait_cyc(QUAL);
      chk_bit("irq early", 1'b0, mfi_irq);
      wait_cyc(QUAL + 8);
      chk_bit("irq raised", 1'b1, mfi_irq);
      rd(LVMON_IRQ_ADDR, x);
      chk_word("irq reg", 32'h3, x);
      supply_mv10 <= 9'h1f4;
      wait_cyc(12);
      wr(LVMON_IRQ_ADDR, 32'h2);
      wait_cyc(2);
      chk_bit("irq cleared", 1'b0, mfi_irq);
      // power-down: a fresh drop wakes, a preset request does not
      wr(LVMON_SLEEP_ADDR, 32'h1);
      w0 = wake_n;
      supply_mv10 <= 9'h064;
      wait_cyc(2 * QUAL + 16);
      chk_bit("sleep irq", 1'b1, mfi_irq);
      chk_word("wake once", 32'(w0 + 1), 32'(wake_n));
      supply_mv10 <= 9'h1f4;
      wait_cyc(12);
      wr(LVMON_IRQ_ADDR, 32'h3);
      w0 = wake_n;
      supply_mv10 <= 9'h064;
      wait_cyc(2 * QUAL + 16);
      chk_word("no wake", 32'(w0), 32'(wake_n));
      wr(LVMON_SLEEP_ADDR, 32'h0);
      apb(1'b0, 12'h010, 32'h0, x, e);
      chk_bit("unmapped err", 1'b1, e);
      chk_word("unmapped data", 32'h0, x);
      complete_run();
   end
endmodule
